// ===== dv/xiu_mem_model.sv
// data memory model on the far side of the extended instruction unit
`timescale 1ns/1ns
module xiu_mem_model (
   input wire clk,
   input wire [11:0] raddr,
   input wire re,
   input wire [11:0] waddr,
   input wire [7:0] wdata,
   input wire we,
   output wire [7:0] rdata
);
   reg [7:0] mem [0:4095];
   reg [7:0] last_reg = 8'h00;
   integer i;
   initial for (i = 0; i < 4096; i = i + 1) mem[i] <= i[7:0] ^ 8'h5A;
   // outside a read the bus shows the inverse of the last byte, so a skipped read passes as zero only after a byte of FF was read
   assign rdata = re ? mem[raddr] : ~last_reg;
   always @(posedge clk) begin
      if (re) last_reg <= mem[raddr];
      if (we) mem[waddr] <= wdata;
   end
endmodule // xiu_mem_model

// ===== dv/xiu_unit_sva.sv
// concurrent checks on the extended instruction unit ports
`timescale 1ns/1ns
module xiu_unit_sva (
   input wire clk,
   input wire rst,
   input wire extension_enable_bit,
   input wire instr_valid,
   input wire [15:0] instr_word,
   input wire [20:0] pc,
   input wire [20:0] return_stack_top,
   input wire [11:0] frame_pointer_reg,
   input wire ext_hit,
   input wire busy,
   input wire [11:0] mem_waddr_reg,
   input wire mem_we_reg,
   input wire stack_push_reg,
   input wire [20:0] stack_push_data_reg,
   input wire pc_load_reg,
   input wire [20:0] pc_load_data_reg
);
   wire take = instr_valid && extension_enable_bit && !busy;
   wire [11:0] lit = {6'h00, instr_word[5:0]};
   wire [11:0] dest = instr_word[11:0];
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_call;
      take && instr_word == 16'h0014;
   endsequence
   sequence s_ret;
      take && instr_word[15:9] == 7'h74 && instr_word[7:6] == 2'h3;
   endsequence
   sequence s_absmove;
      take && instr_word[15:7] == 9'h1D6 ##1 instr_valid && instr_word[15:12] == 4'hF;
   endsequence
   chk_call_push: assert property (s_call |=> stack_push_reg && stack_push_data_reg == $past(pc) + 21'h000002)
      else $error("call push wrong");
   chk_call_idle: assert property (s_call |=> busy && pc_load_reg ##1 !busy && !pc_load_reg)
      else $error("call timing wrong");
   chk_ret_load: assert property (s_ret |=> pc_load_reg && busy && pc_load_data_reg == $past(return_stack_top))
      else $error("return target wrong");
   chk_add_frame: assert property (take && instr_word[15:6] == 10'h3A2
      |=> frame_pointer_reg == $past(frame_pointer_reg) + $past(lit)) else $error("add wrong");
   chk_sub_frame: assert property (take && instr_word[15:6] == 10'h3A6
      |=> frame_pointer_reg == $past(frame_pointer_reg) - $past(lit)) else $error("sub wrong");
   chk_push_store: assert property (take && instr_word[15:8] == 8'hEA |=> mem_we_reg &&
      mem_waddr_reg == $past(frame_pointer_reg) && frame_pointer_reg == $past(frame_pointer_reg) - 12'h001)
      else $error("push wrong");
   chk_abs_write: assert property (s_absmove |=> mem_we_reg && mem_waddr_reg == $past(dest))
      else $error("move write wrong");
   chk_ext_off: assert property (!extension_enable_bit |-> !ext_hit)
      else $error("decode while disabled");
   chk_ext_on: assert property (take && (instr_word[15:10] == 6'h3A || instr_word == 16'h0014) |-> ext_hit)
      else $error("extended word not recognised");
endmodule // xiu_unit_sva
bind xiu_unit xiu_unit_sva i_xiu_unit_sva (.clk(clk), .rst(rst), .extension_enable_bit(extension_enable_bit),
   .instr_valid(instr_valid), .instr_word(instr_word), .pc(pc), .return_stack_top(return_stack_top),
   .frame_pointer_reg(frame_pointer_reg), .ext_hit(ext_hit), .busy(busy), .mem_waddr_reg(mem_waddr_reg),
   .mem_we_reg(mem_we_reg), .stack_push_reg(stack_push_reg), .stack_push_data_reg(stack_push_data_reg),
   .pc_load_reg(pc_load_reg), .pc_load_data_reg(pc_load_data_reg));

// ===== dv/xiu_unit_tb.sv
// self-checking bench for the extended instruction unit
`timescale 1ns/1ns
module xiu_unit_tb;
   reg clk = 0, rst = 1, en = 1, iv = 0;
   reg [15:0] iw = 16'h0000;
   reg [20:0] pcr = 21'h000100;
   reg [7:0] acc = 8'h06;
   wire [7:0] rd, wd;
   wire [11:0] p0, p1, fp, ra, wa;
   wire hit, busy, re, we, sp, pl;
   wire [20:0] sd, pd;
   integer fails = 0, check_count = 0;
   always #5 clk = ~clk;
   xiu_unit i_xiu_unit (.clk(clk), .rst(rst), .extension_enable_bit(en), .instr_valid(iv), .instr_word(iw),
      .pc(pcr), .accumulator(acc), .pc_high_latch(8'h10), .pc_upper_latch(8'h1F),
      .return_stack_top(21'h01234A), .mem_rdata(rd), .ptr0_reg(p0), .ptr1_reg(p1), .frame_pointer_reg(fp),
      .ext_hit(hit), .busy(busy), .mem_raddr_reg(ra), .mem_re_reg(re), .mem_waddr_reg(wa), .mem_wdata_reg(wd),
      .mem_we_reg(we), .stack_push_reg(sp), .stack_push_data_reg(sd), .pc_load_reg(pl), .pc_load_data_reg(pd));
   xiu_mem_model i_xiu_mem_model (.clk(clk), .raddr(ra), .re(re), .waddr(wa), .wdata(wd), .we(we), .rdata(rd));
   task chk(input [31:0] seen, input [31:0] exp, input [39:0] nm);
      check_count = check_count + 1;
      if (seen !== exp) begin
         fails = fails + 1;
         $display("[ERR] %0s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task op(input [15:0] w);
      iw = w;
      iv = 1;
      @(posedge clk) #1;
   endtask
   task gap;
      iv = 0;
      @(posedge clk) #1;
   endtask
   task fin(input [39:0] nm);
      gap;
      $display("%0s done", nm);
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task t_ptr;
      op(16'hE83F);
      chk(p0, 12'h03F, "ptr0");
      op(16'hE941);
      chk(p1, 12'hFFF, "ptr1");
      op(16'hE885);
      chk(fp, 12'h005, "fp");
      chk(hit, 1'b1, "hit");
      en = 0;
      op(16'hE801);
      chk({hit, p0}, 13'h003F, "off");
      en = 1;
      fin("ptr");
   endtask
   task t_ret;
      op(16'hE8C3);
      chk({busy, pl, fp}, {2'h3, 12'h008}, "ret");
      chk(pd, 21'h01234A, "rtgt");
      gap;
      chk({busy, pl}, 2'h0, "idle");
      op(16'hE9C8);
      chk({pl, fp}, 13'h1000, "subr");
      fin("ret");
   endtask
   task t_call;
      op(16'h0014);
      chk({sp, sd}, 22'h200102, "push");
      chk({busy, pd}, 22'h3F1006, "tgt");
      gap;
      chk({busy, sp, pl}, 3'h0, "cidl");
      pcr = 21'h00ABCE;
      acc = 8'hF0;
      op(16'h0014);
      chk({sp, sd}, 22'h20ABD0, "push2");
      chk(pd, 21'h1F10F0, "tgt2");
      fin("call");
   endtask
   task t_push;
      op(16'hEA5A);
      chk({we, wa, wd}, 21'h10005A, "pshw");
      chk(fp, 12'hFFF, "pshf");
      fin("push");
   endtask
   // an unwritten move still loads new write address and data, so only the strobe counts there
   // src holds the expected read strobe above the source address; an indirect source is never read
   task mv(input [15:0] w1, input [15:0] w2, input [12:0] src, input [20:0] res);
      op(w1);
      chk({re, ra}, src, "src");
      op(w2);
      chk({we, we ? {wa, wd} : 20'h00000}, res, "mov");
      gap;
   endtask
   // destinations stay clear of the pc low and stack-top bytes
   task t_move;
      op(16'hE9A0);
      chk(fp, 12'hFDF, "fp");
      mv(16'hEB1F, 16'hF123, 13'h1FFE, 21'h1123A4);
      mv(16'hEB80, 16'hF07F, 13'h0FDF, 21'h105E00);
      mv(16'hEBBF, 16'hF002, 13'h101E, 21'h000000);
      mv(16'hEB9F, 16'h0001, 13'h1FFE, 21'h000000);
      fin("move");
   endtask
   initial begin
      repeat (5) @(posedge clk);
      #1 rst = 0;
      t_ptr;
      t_ret;
      t_call;
      t_push;
      t_move;
      conclude;
   end
   // the scenarios need under a hundred cycles, so two thousand is a generous cap
   initial begin
      #20000;
      fails = fails + 1;
      conclude;
   end
endmodule // xiu_unit_tb

// ===== src/xiu_addr_calc.v
// address arithmetic and indirect register detection for the move unit
`timescale 1ns/1ns
`include "xiu_defines.vh"
module xiu_addr_calc #(
   parameter AW = 12
) (
   input wire [AW-1:0] base,
   input wire [6:0] offset,
   output wire [AW-1:0] addr,
   output wire is_indirect
);
   function is_ind;
      input [AW-1:0] a;
      begin
         // the gaps between pointer groups are ordinary special registers
         is_ind = (a >= `XIU_INDIRECT_LO) && (a <= `XIU_INDIRECT_HI) &&
                  (a != `XIU_INDIRECT_HOLE0) && (a != `XIU_INDIRECT_HOLE1) && (a != `XIU_INDIRECT_HOLE2);
      end
   endfunction

   assign addr = base + {{(AW-7){1'b0}}, offset}; // RL13 RL18
   assign is_indirect = is_ind(addr);
endmodule // xiu_addr_calc

// ===== src/xiu_defines.vh
// constants for the extended instruction unit
//
// Summary of operation
// RL1: add six-bit literal to chosen pointer, one cycle
// RL2: selector 11 means add-and-return on frame pointer
// RL3: add to frame pointer, return, two cycles
// RL4: subtract six-bit literal from chosen pointer, one cycle
// RL5: selector 11 subtracts from frame pointer, returns
// RL6: computed call pushes program counter plus two
// RL7: pc low from accumulator, high/upper from latches
// RL8: computed call two cycles, no accumulator/status change
// RL9: indexed source to twelve-bit absolute destination
// RL10: first word 1110 1011, bit7 picks move kind
// RL11: software never targets pc low or stack top
// RL12: source on indirect register reads as zero
// RL13: both offsets added to frame pointer
// RL14: destination on indirect register means no write; the code checks only indexed destinations, an absolute one is written
// RL15: push literal at frame pointer, then decrement
// RL16: moves span full data space, two words, two cycles
// RL17: extension decoded only when enable bit set
// RL18: pointer arithmetic wraps at twelve bits, no flags
`ifndef XIU_DEFINES_VH
`define XIU_DEFINES_VH
`define XIU_OP_EXT_HI 8'hE8
`define XIU_OP_ADD 4'h8
`define XIU_OP_SUB 4'h9
`define XIU_OP_PUSH 4'hA
`define XIU_OP_MOVE 4'hB
`define XIU_OP_COMPUTED_CALL 16'h0014
`define XIU_OP_WORD2 4'hF
`define XIU_SEL_FRAME 2'h3
`define XIU_SEL_FRAME_IDX 2'h2
`define XIU_SEL_PTR0 2'h0
`define XIU_SEL_PTR1 2'h1
`define XIU_OP_EXT_CLASS 4'hE
`define XIU_PTR_RESET 12'h000
// indirect addressing registers occupy this window of the data space
`define XIU_INDIRECT_LO 12'hFDB
`define XIU_INDIRECT_HI 12'hFEF
`define XIU_INDIRECT_HOLE0 12'hFE0
`define XIU_INDIRECT_HOLE1 12'hFE8
`define XIU_INDIRECT_HOLE2 12'hFEA
`define XIU_PC_STEP 21'h000002
`endif

// ===== src/xiu_unit.v
// decode and execute logic for the extended instruction set
`timescale 1ns/1ns
`include "xiu_defines.vh"
module xiu_unit #(
   parameter AW = 12,
   parameter PCW = 21
) (
   input wire clk,
   input wire rst,
   input wire extension_enable_bit,
   input wire instr_valid,
   input wire [15:0] instr_word,
   input wire [PCW-1:0] pc,
   input wire [7:0] accumulator,
   input wire [7:0] pc_high_latch,
   input wire [7:0] pc_upper_latch,
   input wire [PCW-1:0] return_stack_top,
   input wire [7:0] mem_rdata,
   output reg [AW-1:0] ptr0_reg,
   output reg [AW-1:0] ptr1_reg,
   output reg [AW-1:0] frame_pointer_reg,
   output wire ext_hit,
   output wire busy,
   output reg [AW-1:0] mem_raddr_reg,
   output reg mem_re_reg,
   output reg [AW-1:0] mem_waddr_reg,
   output reg [7:0] mem_wdata_reg,
   output reg mem_we_reg,
   output reg stack_push_reg,
   output reg [PCW-1:0] stack_push_data_reg,
   output reg pc_load_reg,
   output reg [PCW-1:0] pc_load_data_reg
);
   // ----------------------------------------
   // states
   // ----------------------------------------
   localparam ST_IDLE = 2'b00;
   // the idle cycle covers the refetch after a return or a computed call
   localparam ST_IDLE_CYCLE = 2'b01;
   localparam ST_MOVE2 = 2'b10;

   reg [1:0] state_reg;
   reg [1:0] state_next;
   reg move_idx_reg;
   reg src_ind_reg;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   function ext_op;
      input [15:0] w;
      input [3:0] lo;
      begin
         ext_op = (w[15:12] == `XIU_OP_EXT_CLASS) && (w[11:8] == lo);
      end
   endfunction

   wire [1:0] sel = instr_word[7:6];
   wire [5:0] lit6 = instr_word[5:0];
   // nothing is taken in the second cycle of a two-cycle instruction
   wire fire = instr_valid && extension_enable_bit && (state_reg == ST_IDLE); // RL17
   wire is_add = fire && ext_op(instr_word, `XIU_OP_ADD); // RL1
   wire is_sub = fire && ext_op(instr_word, `XIU_OP_SUB); // RL4
   wire is_push = fire && ext_op(instr_word, `XIU_OP_PUSH); // RL15
   wire is_move = fire && ext_op(instr_word, `XIU_OP_MOVE); // RL10
   wire is_computed_call = fire && (instr_word == `XIU_OP_COMPUTED_CALL); // RL6
   wire is_ret = (is_add || is_sub) && (sel == `XIU_SEL_FRAME); // RL2 RL5
   wire word2_ok = instr_valid && (instr_word[15:12] == `XIU_OP_WORD2); // RL10

   // busy counts as a hit so the core keeps treating the second cycle as ours
   assign ext_hit = is_add || is_sub || is_push || is_move || is_computed_call || (state_reg != ST_IDLE);
   assign busy = (state_reg != ST_IDLE);

   // ----------------------------------------
   // address arithmetic
   // ----------------------------------------
   wire [AW-1:0] src_addr;
   wire src_ind;
   wire [AW-1:0] dst_addr;
   wire dst_ind;
   wire [AW-1:0] dst_abs = instr_word[AW-1:0]; // RL9 RL16

   xiu_addr_calc #(.AW(AW)) u_src (
      .base(frame_pointer_reg),
      .offset(instr_word[6:0]),
      .addr(src_addr),
      .is_indirect(src_ind)
   );
   // the destination offset comes from the second word, so it is formed in the second cycle
   xiu_addr_calc #(.AW(AW)) u_dst (
      .base(frame_pointer_reg),
      .offset(instr_word[6:0]),
      .addr(dst_addr),
      .is_indirect(dst_ind)
   );

   wire [AW-1:0] lit_ext = {{(AW-6){1'b0}}, lit6};

   function [AW-1:0] ptr_step;
      input [AW-1:0] p;
      input [AW-1:0] k;
      input sub;
      begin
         ptr_step = sub ? (p - k) : (p + k); // RL18
      end
   endfunction

   wire [AW-1:0] ptr_one = {{(AW-1){1'b0}}, 1'b1};

   // ----------------------------------------
   // pointer next values
   // ----------------------------------------
   reg [AW-1:0] ptr0_next;
   reg [AW-1:0] ptr1_next;
   reg [AW-1:0] frame_pointer_next;

   always @* begin
      ptr0_next = ptr0_reg;
      ptr1_next = ptr1_reg;
      frame_pointer_next = frame_pointer_reg;
      if (is_add || is_sub) begin
         // no status flag output exists, so flags cannot change
         case (sel)
            `XIU_SEL_PTR0: begin
               ptr0_next = ptr_step(ptr0_reg, lit_ext, is_sub); // RL1 RL4
            end
            `XIU_SEL_PTR1: begin
               ptr1_next = ptr_step(ptr1_reg, lit_ext, is_sub); // RL1 RL4
            end
            default: begin
               // selector 10 and the return form 11 both act on the frame pointer
               frame_pointer_next = ptr_step(frame_pointer_reg, lit_ext, is_sub); // RL1 RL2 RL3 RL4 RL5
            end
         endcase
      end else if (is_push) begin
         // the store takes the old value; the decrement lands on the same edge
         frame_pointer_next = ptr_step(frame_pointer_reg, ptr_one, 1'b1); // RL15 RL18
      end
   end

   // ----------------------------------------
   // sequencing
   // ----------------------------------------
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (is_ret || is_computed_call) begin
               state_next = ST_IDLE_CYCLE; // RL3 RL5 RL8
            end else if (is_move) begin
               state_next = ST_MOVE2; // RL16
            end
         end
         ST_IDLE_CYCLE: state_next = ST_IDLE;
         ST_MOVE2: begin
            // the core holds off fetch while busy; wait for the second word
            if (instr_valid) begin
               state_next = ST_IDLE;
            end
         end
         default: state_next = ST_IDLE;
      endcase
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always @(posedge clk) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         ptr0_reg <= `XIU_PTR_RESET;
         ptr1_reg <= `XIU_PTR_RESET;
         frame_pointer_reg <= `XIU_PTR_RESET;
         move_idx_reg <= 1'b0;
         src_ind_reg <= 1'b0;
         mem_raddr_reg <= {AW{1'b0}};
         mem_re_reg <= 1'b0;
         mem_waddr_reg <= {AW{1'b0}};
         mem_wdata_reg <= 8'h00;
         mem_we_reg <= 1'b0;
         stack_push_reg <= 1'b0;
         stack_push_data_reg <= {PCW{1'b0}};
         pc_load_reg <= 1'b0;
         pc_load_data_reg <= {PCW{1'b0}};
      end else begin
         state_reg <= state_next;
         mem_re_reg <= 1'b0;
         mem_we_reg <= 1'b0;
         stack_push_reg <= 1'b0;
         pc_load_reg <= 1'b0;
         ptr0_reg <= ptr0_next;
         ptr1_reg <= ptr1_next;
         frame_pointer_reg <= frame_pointer_next;
         if (is_ret) begin
            pc_load_reg <= 1'b1; // RL3 RL5
            pc_load_data_reg <= return_stack_top;
         end
         if (is_push) begin
            mem_waddr_reg <= frame_pointer_reg; // RL15
            mem_wdata_reg <= instr_word[7:0];
            mem_we_reg <= 1'b1;
         end
         if (is_computed_call) begin
            stack_push_reg <= 1'b1; // RL6
            stack_push_data_reg <= pc + `XIU_PC_STEP;
            pc_load_reg <= 1'b1; // RL7 RL8
            pc_load_data_reg <= {pc_upper_latch[PCW-17:0], pc_high_latch, accumulator};
         end
         if (is_move) begin
            // the source is read now so its byte stands while the second word arrives
            move_idx_reg <= instr_word[7]; // RL10
            src_ind_reg <= src_ind;
            mem_raddr_reg <= src_addr; // RL9 RL13
            mem_re_reg <= ~src_ind;
         end
         if (state_reg == ST_MOVE2 && instr_valid) begin
            // a malformed second word is dropped rather than written anywhere
            mem_waddr_reg <= move_idx_reg ? dst_addr : dst_abs; // RL9 RL13
            mem_wdata_reg <= src_ind_reg ? 8'h00 : mem_rdata; // RL12
            mem_we_reg <= word2_ok && !(move_idx_reg && dst_ind); // RL14
         end
      end
   end
endmodule // xiu_unit
